// *** hdl/mpsl_top.sv ***
// Process setpoint logic: label entry, stop handling, analog low alarm.
// Assumes keys, contacts and start/stop requests arrive as raw pins,
// the analog current code comes from logic on clk.
//
// Behaviour
// - Fourteen user labels of twenty characters each
// - Value keys step char, commit stores and advances
// - Commit at last position wraps cursor to start
// - Selectable character set includes blank space
// - Stored labels feed the display read port
// - Contactor dropout without stop command flags event
// - Unlatched dropout: indication only, no trip
// - Latched dropout: emergency trip blocks restart
// - Latched faceplate stop trips; reset clears it
// - Latched process stop: momentary opening trips
// - Held start restarts motor at reset
// - Scale maps low and high current ends
// - Minimum scale 0..20000 in steps of ten
// - Maximum scale 10..20000 in steps of ten
// - Low alarm below level; 1..20000 or off
// - Low alarm after settable continuous delay
`timescale 1ns/100ps
module mpsl_top
  import mpsl_pkg::*;
#(
  parameter int TICKS_SEC = TICKS_PER_SEC
)(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              key_up,
  input  wire logic              key_down,
  input  wire logic              key_commit,
  input  wire logic              key_stop,
  input  wire logic              key_reset,
  input  wire logic              proc_stop_ok,
  input  wire logic              start_req,
  input  wire logic              cont_a_closed,
  input  wire logic              cont_b_closed,
  input  wire logic              stop_cmd,
  input  wire logic [VAL_W-1:0]  cur_ua,
  input  wire logic [3:0]        disp_label,
  input  wire logic [4:0]        disp_pos,
  output logic      [7:0]        disp_char,
  output logic                   ext_stop_ind,
  output logic                   run_permit,
  output logic                   motor_start,
  output logic                   motor_stop,
  output logic                   low_alarm,
  output logic                   irq
);
  import mpsl_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic on_step(input logic [VAL_W-1:0] v);
    on_step = (v % SCALE_STEP) == '0;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [PIN_W-1:0] pin_d_r;
  logic [PIN_W-1:0] pin_rise;
  logic [PIN_W-1:0] pin_fall;

  assign pin_raw = {stop_cmd, cont_b_closed, cont_a_closed, start_req, proc_stop_ok,
                    key_reset, key_stop, key_commit, key_down, key_up};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r  <= '0;
    end else if (ce) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  assign pin_rise = pin_s2_r & ~pin_d_r;
  assign pin_fall = ~pin_s2_r & pin_d_r;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic [7:0]       ctrl_r;
  logic [EV_W-1:0]  status_r;
  logic [EV_W-1:0]  status_nxt;
  logic [EV_W-1:0]  mask_r;
  logic [VAL_W-1:0] min_r;
  logic [VAL_W-1:0] max_r;
  logic [VAL_W-1:0] low_lvl_r;
  logic [9:0]       low_dly_r;
  logic [VAL_W-1:0] wval;
  logic             wr_ctrl;
  logic             wr_stat;
  logic             wr_mask;
  logic             wr_min;
  logic             wr_max;
  logic             wr_lvl;
  logic             wr_dly;

  assign wval    = reg_wdata[VAL_W-1:0];
  assign wr_ctrl = reg_wr & hit(reg_addr, OFS_CTRL);
  assign wr_stat = reg_wr & hit(reg_addr, OFS_STATUS);
  assign wr_mask = reg_wr & hit(reg_addr, OFS_MASK);
  // Out-of-range or off-step writes are dropped, old value kept
  assign wr_min  = reg_wr & hit(reg_addr, OFS_MIN) & (reg_wdata <= 32'(SCALE_TOP))
                   & on_step(wval);
  assign wr_max  = reg_wr & hit(reg_addr, OFS_MAX) & (reg_wdata <= 32'(SCALE_TOP))
                   & (reg_wdata >= 32'(SCALE_STEP)) & on_step(wval);
  // Zero written means off
  assign wr_lvl  = reg_wr & hit(reg_addr, OFS_LOW_LVL)
                   & (reg_wdata <= 32'(SCALE_TOP));
  assign wr_dly  = reg_wr & hit(reg_addr, OFS_LOW_DLY)
                   & (reg_wdata <= 32'(DLY_TOP));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r    <= '0;
      mask_r    <= '0;
      min_r     <= MIN_RST;
      max_r     <= MAX_RST;
      low_lvl_r <= LOW_LVL_RST;
      low_dly_r <= LOW_DLY_RST;
    end else if (ce) begin
      if (wr_ctrl) ctrl_r <= reg_wdata[7:0];
      if (wr_mask) mask_r <= reg_wdata[EV_W-1:0];
      if (wr_min) min_r <= wval;
      if (wr_max) max_r <= wval;
      if (wr_lvl) low_lvl_r <= wval;
      if (wr_dly) low_dly_r <= reg_wdata[9:0];
    end
  end

  // ----------------------------------------
  // Label store and editing
  // ----------------------------------------
  logic [7:0] label_mem [LABEL_SLOTS][LABEL_LEN];
  logic [3:0] sel;
  logic [4:0] cursor_r;
  logic [4:0] cursor_nxt;
  logic [7:0] edit_r;
  logic [7:0] edit_nxt;
  logic       sel_ok;
  logic       do_commit;

  assign sel       = ctrl_r[CTRL_SEL_LSB +: 4];
  assign sel_ok    = sel < 4'(LABEL_SLOTS);
  assign do_commit = pin_rise[PIN_COMMIT] & sel_ok;
  // Wrap from last position back to first
  assign cursor_nxt = (cursor_r == 5'(LABEL_LEN - 1)) ? '0 : cursor_r + 5'h01;

  // Space is the bottom of the character set
  always_comb begin
    edit_nxt = edit_r;
    if (pin_rise[PIN_UP]) begin
      edit_nxt = (edit_r >= CHAR_LAST) ? CHAR_SPACE : edit_r + 8'h01;
    end else if (pin_rise[PIN_DOWN]) begin
      edit_nxt = (edit_r <= CHAR_SPACE) ? CHAR_LAST : edit_r - 8'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cursor_r <= '0;
      edit_r   <= CHAR_SPACE;
    end else if (ce) begin
      if (wr_ctrl) begin
        cursor_r <= '0;
        edit_r   <= CHAR_SPACE;
      end else if (do_commit) begin
        cursor_r <= cursor_nxt;
        edit_r   <= label_mem[sel][cursor_nxt];
      end else begin
        edit_r   <= edit_nxt;
      end
    end
  end

  // Whole store resets to blanks so a fresh label is readable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < LABEL_SLOTS; i++) begin
        for (int j = 0; j < LABEL_LEN; j++) begin
          label_mem[i][j] <= CHAR_SPACE;
        end
      end
    end else if (ce && do_commit) begin
      label_mem[sel][cursor_r] <= edit_r;
    end
  end

  // Display port; out-of-range requests read as blank
  logic disp_ok;
  assign disp_ok = (disp_label < 4'(LABEL_SLOTS)) && (disp_pos < 5'(LABEL_LEN));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      disp_char <= CHAR_SPACE;
    end else if (ce) begin
      disp_char <= disp_ok ? label_mem[disp_label][disp_pos] : CHAR_SPACE;
    end
  end

  // ----------------------------------------
  // Stop sources and trips
  // ----------------------------------------
  logic stop_seen_r;
  logic dropout;
  logic proc_open;
  logic estop_r;
  logic fp_trip_r;
  logic proc_trip_r;
  logic estop_nxt;
  logic fp_nxt;
  logic proc_nxt;
  logic trip_nxt;
  logic trip_any;
  logic rst_key;
  logic ext_set;
  logic start_go;

  assign rst_key  = pin_rise[PIN_RESETKEY];
  // A dropout counts only if no stop was asked for since the last start
  assign dropout  = (pin_fall[PIN_CONT_A] | pin_fall[PIN_CONT_B])
                    & ~stop_seen_r & ~pin_s2_r[PIN_STOPCMD];
  assign proc_open = ~pin_s2_r[PIN_PROC_OK];
  assign ext_set  = dropout & ~ctrl_r[CTRL_FIELD_LATCH];
  // Set wins over reset key in the same cycle
  assign estop_nxt = (dropout & ctrl_r[CTRL_FIELD_LATCH]) | (estop_r & ~rst_key);
  assign fp_nxt    = (pin_rise[PIN_STOPKEY] & ctrl_r[CTRL_FP_LATCH])
                     | (fp_trip_r & ~rst_key);
  // Level test: even one sampled cycle of opening latches
  assign proc_nxt  = (proc_open & ctrl_r[CTRL_PROC_LATCH])
                     | (proc_trip_r & ~rst_key);
  assign trip_nxt  = estop_nxt | fp_nxt | proc_nxt;
  assign trip_any  = estop_r | fp_trip_r | proc_trip_r;
  // Start on a fresh request, or on a held one when trips clear
  assign start_go  = pin_s2_r[PIN_START] & ~trip_nxt
                     & (pin_rise[PIN_START] | (trip_any & rst_key));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_seen_r  <= 1'b0;
      estop_r      <= 1'b0;
      fp_trip_r    <= 1'b0;
      proc_trip_r  <= 1'b0;
      ext_stop_ind <= 1'b0;
      run_permit   <= 1'b1;
      motor_start  <= 1'b0;
      motor_stop   <= 1'b0;
    end else if (ce) begin
      if (start_go) stop_seen_r <= 1'b0;
      else if (pin_s2_r[PIN_STOPCMD] | pin_rise[PIN_STOPKEY]) stop_seen_r <= 1'b1;
      estop_r     <= estop_nxt;
      fp_trip_r   <= fp_nxt;
      proc_trip_r <= proc_nxt;
      if (ext_set) ext_stop_ind <= 1'b1;
      else if (start_go) ext_stop_ind <= 1'b0;
      run_permit  <= ~trip_nxt;
      motor_start <= start_go;
      motor_stop  <= pin_rise[PIN_STOPKEY] | pin_fall[PIN_PROC_OK] | dropout;
    end
  end

  // ----------------------------------------
  // Analog scaling and low alarm
  // ----------------------------------------
  logic [VAL_W-1:0] scaled;
  logic [31:0]      tick_r;
  logic [9:0]       secs_r;
  logic             below;
  logic             sec_tick;
  logic             low_nxt;

  mpsl_scale u_scale (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .cur_ua    (cur_ua),
    .scale_min (min_r),
    .scale_max (max_r),
    .scaled    (scaled)
  );

  assign below    = (low_lvl_r != '0) && (scaled < low_lvl_r);
  assign sec_tick = tick_r == 32'(TICKS_SEC - 1);
  // Delay off means alarm follows the comparison directly
  assign low_nxt  = below & ((low_dly_r == '0) | (secs_r >= low_dly_r));

  // Timer restarts whenever the value climbs back over the level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_r    <= '0;
      secs_r    <= '0;
      low_alarm <= 1'b0;
    end else if (ce) begin
      if (!below) begin
        tick_r <= '0;
        secs_r <= '0;
      end else if (sec_tick) begin
        tick_r <= '0;
        if (secs_r != DLY_TOP) secs_r <= secs_r + 10'h001;
      end else begin
        tick_r <= tick_r + 32'h00000001;
      end
      low_alarm <= low_nxt;
    end
  end

  // ----------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------
  logic [EV_W-1:0] ev_set;

  assign ev_set = {low_nxt & ~low_alarm, proc_nxt & ~proc_trip_r,
                   fp_nxt & ~fp_trip_r, estop_nxt & ~estop_r, ext_set};
  // Hardware set beats a same-cycle write-one clear
  assign status_nxt = ev_set | (status_r & ~(wr_stat ? reg_wdata[EV_W-1:0] : '0));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= '0;
      irq      <= 1'b0;
    end else if (ce) begin
      status_r <= status_nxt;
      irq      <= |(status_nxt & mask_r);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] state_word;

  assign state_word = {11'h000, edit_r, 3'b000, cursor_r,
                       low_alarm, ext_stop_ind, proc_trip_r, fp_trip_r, estop_r};

  always_comb begin
    case (reg_addr)
      OFS_CTRL:    rd_mux = {24'h000000, ctrl_r};
      OFS_STATUS:  rd_mux = {27'h0000000, status_r};
      OFS_MASK:    rd_mux = {27'h0000000, mask_r};
      OFS_MIN:     rd_mux = {17'h00000, min_r};
      OFS_MAX:     rd_mux = {17'h00000, max_r};
      OFS_LOW_LVL: rd_mux = {17'h00000, low_lvl_r};
      OFS_LOW_DLY: rd_mux = {22'h000000, low_dly_r};
      OFS_SCALED:  rd_mux = {17'h00000, scaled};
      OFS_STATE:   rd_mux = state_word;
      default:     rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end
endmodule

// *** include/mpsl_pkg.sv ***
// Package: constants for the process setpoint block.
// Assumes one 125 MHz clock and a plain word-addressed register port.
package mpsl_pkg;
  // ----------------------------------------
  // Widths and label store
  // ----------------------------------------
  localparam int          LABEL_LEN     = 20;
  localparam int          LABEL_NUM     = 13;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          VAL_W         = 15;
  // Label slots: 0..9 interlocks, 10 counter name, 11 counter unit, 12/13 analog
  localparam logic [3:0]  LBL_CNT_NAME  = 4'hA;
  localparam logic [3:0]  LBL_CNT_UNIT  = 4'hB;
  localparam logic [3:0]  LBL_AN_NAME   = 4'hC;
  localparam logic [3:0]  LBL_AN_UNIT   = 4'hD;
  localparam int          LABEL_SLOTS   = 14;
  localparam logic [7:0]  CHAR_SPACE    = 8'h20;
  localparam logic [7:0]  CHAR_LAST     = 8'h7E;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_MASK      = 8'h08;
  localparam logic [7:0]  OFS_MIN       = 8'h0C;
  localparam logic [7:0]  OFS_MAX       = 8'h10;
  localparam logic [7:0]  OFS_LOW_LVL   = 8'h14;
  localparam logic [7:0]  OFS_LOW_DLY   = 8'h18;
  localparam logic [7:0]  OFS_SCALED    = 8'h1C;
  localparam logic [7:0]  OFS_STATE     = 8'h20;
  // ----------------------------------------
  // Fields
  // ----------------------------------------
  localparam int          CTRL_FIELD_LATCH = 0;
  localparam int          CTRL_FP_LATCH    = 1;
  localparam int          CTRL_PROC_LATCH  = 2;
  localparam int          CTRL_SEL_LSB     = 4;
  localparam int          EV_EXT_STOP   = 0;
  localparam int          EV_ESTOP      = 1;
  localparam int          EV_FP_TRIP    = 2;
  localparam int          EV_PROC_TRIP  = 3;
  localparam int          EV_LOW_ALARM  = 4;
  localparam int          EV_W          = 5;
  // ----------------------------------------
  // Reset values and ranges
  // ----------------------------------------
  localparam logic [14:0] MIN_RST       = 15'h0000;
  localparam logic [14:0] MAX_RST       = 15'h03E8;
  localparam logic [14:0] LOW_LVL_RST   = 15'h0000;
  localparam logic [9:0]  LOW_DLY_RST   = 10'h005;
  localparam logic [14:0] SCALE_TOP     = 15'h4E20;
  localparam logic [14:0] SCALE_STEP    = 15'h000A;
  localparam logic [9:0]  DLY_TOP       = 10'h258;
  // Input current in microamps
  localparam logic [14:0] CUR_LO_UA     = 15'h0FA0;
  localparam logic [14:0] CUR_SPAN_UA   = 15'h3E80;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint      CLK_PERIOD_PS = 8000;
  localparam longint      SECOND_PS     = 64'd1000000000000;
  localparam int          TICKS_PER_SEC = int'(SECOND_PS / CLK_PERIOD_PS);
  // Pin indices of the synchronised input vector
  localparam int          PIN_UP        = 0;
  localparam int          PIN_DOWN      = 1;
  localparam int          PIN_COMMIT    = 2;
  localparam int          PIN_STOPKEY   = 3;
  localparam int          PIN_RESETKEY  = 4;
  localparam int          PIN_PROC_OK   = 5;
  localparam int          PIN_START     = 6;
  localparam int          PIN_CONT_A    = 7;
  localparam int          PIN_CONT_B    = 8;
  localparam int          PIN_STOPCMD   = 9;
  localparam int          PIN_W         = 10;
endpackage

// *** hdl/mpsl_scale.sv ***
// Linear scaling of the 4-20 mA input onto the user scale.
// Assumes the current code comes from logic on the same clock.
`timescale 1ns/100ps
module mpsl_scale
  import mpsl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  input  wire logic [VAL_W-1:0] cur_ua,
  input  wire logic [VAL_W-1:0] scale_min,
  input  wire logic [VAL_W-1:0] scale_max,
  output logic      [VAL_W-1:0] scaled
);
  // ----------------------------------------
  // Offset into the span, clamped
  // ----------------------------------------
  logic [VAL_W-1:0] above_lo;
  logic [VAL_W-1:0] pos;
  logic signed [16:0] span;
  logic signed [33:0] prod;
  logic signed [33:0] quot;
  logic signed [17:0] sum;
  logic [VAL_W-1:0] res;

  assign above_lo = (cur_ua > CUR_LO_UA) ? cur_ua - CUR_LO_UA : '0;
  assign pos      = (above_lo > CUR_SPAN_UA) ? CUR_SPAN_UA : above_lo;
  // Signed span keeps an inverted scale sensible
  assign span     = $signed({2'b00, scale_max}) - $signed({2'b00, scale_min});
  assign prod     = $signed({19'h00000, pos}) * 34'(span);
  assign quot     = prod / $signed({19'h00000, CUR_SPAN_UA});
  assign sum      = $signed({3'b000, scale_min}) + 18'(quot);
  assign res      = (sum < 0) ? '0 : sum[VAL_W-1:0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scaled <= '0;
    end else if (ce) begin
      scaled <= res;
    end
  end
endmodule

// *** tb/mpsl_top_monitor.sv ***
// Checker: port-level properties of the process setpoint block.
// Assumes one clock, ce held high; bound to every mpsl_top instance.
`timescale 1ns/100ps
module mpsl_top_monitor
  import mpsl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              key_stop,
  input  wire logic              key_reset,
  input  wire logic              proc_stop_ok,
  input  wire logic [3:0]        disp_label,
  input  wire logic [4:0]        disp_pos,
  input  wire logic [7:0]        disp_char,
  input  wire logic              run_permit,
  input  wire logic              motor_start,
  input  wire logic              motor_stop
);
  logic [3:0] rst_age_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------
  // Age of the reset key, saturating
  // ------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_age_r <= 4'hF;
    end else if (key_reset) begin
      rst_age_r <= 4'h0;
    end else if (rst_age_r != 4'hF) begin
      rst_age_r <= rst_age_r + 4'h1;
    end
  end
  chk_disp_charset: assert property (
    disp_char >= CHAR_SPACE && disp_char <= CHAR_LAST) else $error("display char out of set");
  chk_label_slot: assert property (
    disp_label >= 4'hE |=> disp_char == CHAR_SPACE) else $error("bad slot not blank");
  chk_label_len: assert property (
    disp_pos >= 5'h14 |=> disp_char == CHAR_SPACE) else $error("position past label end");
  chk_min_range: assert property (
    reg_rd && reg_addr == OFS_MIN |=> reg_rdata <= 20000 && reg_rdata % 10 == 0)
    else $error("minimum scale off grid");
  chk_max_range: assert property (
    reg_rd && reg_addr == OFS_MAX |=> reg_rdata >= 10 && reg_rdata <= 20000
    && reg_rdata % 10 == 0) else $error("maximum scale off grid");
  chk_start_permit: assert property (
    motor_start |-> run_permit) else $error("start while tripped");
  chk_stop_key: assert property (
    $rose(key_stop) |-> ##[2:6] motor_stop) else $error("stop key ignored");
  chk_proc_open: assert property (
    $fell(proc_stop_ok) |-> ##[2:6] motor_stop) else $error("process opening ignored");
  chk_trip_release: assert property (
    $rose(run_permit) |-> rst_age_r < 4'h8) else $error("trip cleared without reset key");
endmodule

bind mpsl_top mpsl_top_monitor u_mon (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .key_stop(key_stop), .key_reset(key_reset),
  .proc_stop_ok(proc_stop_ok), .disp_label(disp_label), .disp_pos(disp_pos),
  .disp_char(disp_char), .run_permit(run_permit), .motor_start(motor_start),
  .motor_stop(motor_stop)
);

// *** tb/mpsl_field_model.sv ***
// Far side: keypad, start pin, process contact and two contactors.
// Assumes the bench calls its tasks; outputs change after rising edges.
`timescale 1ns/100ps
module mpsl_field_model (
  input  wire logic       clk,
  input  wire logic       motor_start,
  input  wire logic       motor_stop,
  output logic      [4:0] keys,
  output logic            start_req,
  output logic            proc_ok,
  output logic            cont_a,
  output logic            cont_b
);
  initial begin
    keys = 5'h00;
    start_req = 1'b0;
    proc_ok = 1'b1;
    cont_a = 1'b0;
    cont_b = 1'b0;
  end
  // ------------------------------------------
  // Contactors follow the coil pulses
  // ------------------------------------------
  always @(posedge clk) begin
    if (motor_start === 1'b1) begin
      cont_a <= 1'b1;
      cont_b <= 1'b1;
    end else if (motor_stop === 1'b1) begin
      cont_a <= 1'b0;
      cont_b <= 1'b0;
    end
  end
  // Held well past the three-flop pin path
  task automatic press(input int k);
    @(posedge clk);
    keys[k] <= 1'b1;
    repeat (4) @(posedge clk);
    keys[k] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic drop(input logic b);
    @(posedge clk);
    if (b) cont_b <= 1'b0;
    else cont_a <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic hold_start(input logic v);
    @(posedge clk);
    start_req <= v;
    repeat (6) @(posedge clk);
  endtask
  // One-cycle opening, the shortest the contact can show
  task automatic blip_proc();
    @(posedge clk);
    proc_ok <= 1'b0;
    @(posedge clk);
    proc_ok <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

// *** tb/tb_mpsl_top.sv ***
// Bench for mpsl_top: register port, keypad, stops, scaling, low alarm.
// Assumes mpsl_pkg is compiled first; ticks per second cut to 10.
`timescale 1ns/100ps
module tb_mpsl_top;
  import mpsl_pkg::*;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0, ce = 1, stop_cmd = 0;
  logic [7:0] reg_addr = 0, disp_char;
  logic [31:0] reg_wdata = 0, reg_rdata, e;
  logic [14:0] cur_ua = 15'h4E20;
  logic [3:0] disp_label = 0;
  logic [4:0] disp_pos = 0, keys;
  logic start_req, proc_ok, cont_a, cont_b, ext_stop_ind, run_permit;
  logic motor_start, motor_stop, low_alarm, irq;
  logic [63:0] q[$], n;
  int fail_count = 0, comparisons = 0, starts = 0, c;
  logic [7:0] ta[9] = '{OFS_CTRL, OFS_MASK, 8'h40, OFS_MIN, OFS_MIN, OFS_MIN, OFS_MAX,
                        OFS_LOW_LVL, OFS_LOW_DLY};
  int td[9] = '{0, 0, 7, 15, 20010, 20000, 5, 20001, 601};
  int te[9] = '{0, 0, 0, 0, 0, 20000, 1000, 0, 5};
  always #4 clk = ~clk;
  mpsl_top #(.TICKS_SEC(10)) dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_up(keys[0]),
    .key_down(keys[1]), .key_commit(keys[2]), .key_stop(keys[3]), .key_reset(keys[4]),
    .proc_stop_ok(proc_ok), .start_req(start_req), .cont_a_closed(cont_a),
    .cont_b_closed(cont_b), .stop_cmd(stop_cmd), .cur_ua(cur_ua), .disp_label(disp_label),
    .disp_pos(disp_pos), .disp_char(disp_char), .ext_stop_ind(ext_stop_ind),
    .run_permit(run_permit), .motor_start(motor_start), .motor_stop(motor_stop),
    .low_alarm(low_alarm), .irq(irq));
  mpsl_field_model fm (
    .clk(clk), .motor_start(motor_start), .motor_stop(motor_stop), .keys(keys),
    .start_req(start_req), .proc_ok(proc_ok), .cont_a(cont_a), .cont_b(cont_b));
  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
    comparisons++;
    if (y !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Expected word goes in the queue; the bench read check below compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    @(posedge clk);
    q.push_back({m, x & m});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse_start();
    fm.hold_start(1'b1);
    fm.hold_start(1'b0);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_seen) begin
      n = q.pop_front();
      chk("reg_rdata", n[31:0], reg_rdata & n[63:32]);
    end
    rd_seen <= reg_rd;
  end
  always @(posedge clk) if (motor_start === 1'b1) starts <= starts + 1;
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    void'($urandom(45859));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      e = ta[i] == OFS_MAX ? 32'(MAX_RST) : ta[i] == OFS_LOW_DLY ? 32'(LOW_DLY_RST) : 0;
      rd(ta[i], e, '1);
    end
    for (int i = 3; i < 9; i++) begin
      wr(ta[i], td[i]);
      rd(ta[i], te[i], '1);
    end
    c = 10 * ($urandom % 2001);
    wr(OFS_MIN, c);
    rd(OFS_MIN, c, '1);
    // Labels: slot 10, two steps up, one commit
    wr(OFS_CTRL, 32'hA0);
    fm.press(0);
    fm.press(0);
    fm.press(2);
    disp_label <= 4'hA;
    repeat (2) @(posedge clk);
    chk("disp_char", 8'h22, disp_char);
    rd(OFS_STATE, (32'h20 << 13) | (1 << 5), 32'h1FE3E0);
    repeat (19) fm.press(2);
    rd(OFS_STATE, 32'h22 << 13, 32'h1FE3E0);
    // Frozen clock enable: a whole key press goes unseen
    ce <= 1'b0;
    fm.press(0);
    ce <= 1'b1;
    rd(OFS_STATE, 32'h22 << 13, 32'h1FE3E0);
    wr(OFS_CTRL, 32'hA0);
    fm.press(1);
    fm.press(2);
    chk("disp_char", 8'h7E, disp_char);
    disp_pos <= 5'h13;
    repeat (2) @(posedge clk);
    chk("disp_char", 8'h20, disp_char);
    disp_label <= 4'hF;
    disp_pos <= 5'h14;
    repeat (2) @(posedge clk);
    chk("disp_char", 8'h20, disp_char);
    // Stops, unlatched then latched
    wr(OFS_CTRL, 0);
    pulse_start();
    chk("starts", 1, starts);
    fm.drop(1'b0);
    chk("ext_stop_ind", 1, ext_stop_ind);
    chk("run_permit", 1, run_permit);
    wr(OFS_CTRL, 1);
    pulse_start();
    // Dropout after a stop command is no external stop
    stop_cmd <= 1'b1;
    fm.drop(1'b0);
    chk("run_permit", 1, run_permit);
    stop_cmd <= 1'b0;
    pulse_start();
    fm.drop(1'b1);
    chk("run_permit", 0, run_permit);
    pulse_start();
    chk("starts", 3, starts);
    fm.hold_start(1'b1);
    fm.press(4);
    chk("starts", 4, starts);
    chk("run_permit", 1, run_permit);
    fm.hold_start(1'b0);
    wr(OFS_CTRL, 2);
    fm.press(3);
    chk("run_permit", 0, run_permit);
    fm.press(4);
    chk("run_permit", 1, run_permit);
    wr(OFS_CTRL, 4);
    fm.blip_proc();
    chk("run_permit", 0, run_permit);
    fm.press(4);
    chk("run_permit", 1, run_permit);
    rd(OFS_STATUS, 32'h0F, 32'h1F);
    wr(OFS_MASK, 1);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    wr(OFS_STATUS, 32'h1F);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    // Scaling, ends and random mid-span currents
    wr(OFS_MIN, 100);
    wr(OFS_MAX, 1100);
    for (int i = 0; i < 7; i++) begin
      c = i == 0 ? 2000 : i == 1 ? 20000 : 4000 + $urandom % 16001;
      cur_ua <= c[14:0];
      repeat (3) @(posedge clk);
      e = c < 4000 ? 100 : 100 + (c - 4000) * 1000 / 16000;
      rd(OFS_SCALED, e, 32'h7FFF);
    end
    // Low alarm after two seconds below the level
    wr(OFS_MASK, 32'h10);
    wr(OFS_LOW_DLY, 2);
    wr(OFS_LOW_LVL, 500);
    cur_ua <= 15'h0FA0;
    repeat (18) @(posedge clk);
    chk("low_alarm", 0, low_alarm);
    repeat (14) @(posedge clk);
    chk("low_alarm", 1, low_alarm);
    chk("irq", 1, irq);
    end_of_test();
  end
endmodule
